// [logic/sfelp_consts.svh]
// constants for the serial flash erase, lock and power-down sequencer
`ifndef SFELP_CONSTS_SVH
`define SFELP_CONSTS_SVH

// system clock rate
`define SFELP_CLK_MHZ 50

// command codes
`define SFELP_OP_WREN 8'h06
`define SFELP_OP_WRDI 8'h04
`define SFELP_OP_LOCK_WR 8'hE5
`define SFELP_OP_PAGE_ERASE 8'hDB
`define SFELP_OP_SUB_ERASE 8'h20
`define SFELP_OP_SECT_ERASE 8'hD8
`define SFELP_OP_BULK_ERASE 8'hC7
`define SFELP_OP_DPD 8'hB9
`define SFELP_OP_RDPD 8'hAB

// frame lengths in bits: code, code plus address, plus one data byte
`define SFELP_BITS_CODE 6'h08
`define SFELP_BITS_ADDR 6'h20
`define SFELP_BITS_DATA 6'h28

// lock byte fields and reset value
`define SFELP_LOCK_WR_BIT 0
`define SFELP_LOCK_DN_BIT 1
`define SFELP_LOCK_RESET 8'h00

// region boundaries within the byte address
`define SFELP_PAGE_LSB 8
`define SFELP_SUB_LSB 12
`define SFELP_SECT_LSB 16

// self-timed durations
`define SFELP_PAGE_ERASE_US 10000
`define SFELP_SUB_ERASE_US 150000
`define SFELP_SECT_ERASE_US 1000000
`define SFELP_BULK_ERASE_US 2000000
`define SFELP_PD_ENTRY_NS 3000
`define SFELP_PD_RELEASE_NS 30000
`define SFELP_RESET_RECOVER_NS 30000

`endif

// [logic/sfelp_pkg.sv]
// types of the serial flash erase, lock and power-down sequencer
`default_nettype none
package sfelp_pkg;

  // sequencer modes
  typedef enum logic [2:0] {
    SFELP_ST_IDLE,
    SFELP_ST_ERASE,
    SFELP_ST_PD_ENTRY,
    SFELP_ST_PD,
    SFELP_ST_PD_EXIT,
    SFELP_ST_RESET
  } sfelp_state_t;

  // kind of erase cycle
  typedef enum logic [1:0] {
    SFELP_ER_PAGE,
    SFELP_ER_SUB,
    SFELP_ER_SECT,
    SFELP_ER_BULK
  } sfelp_erase_t;

  // erase order toward the array
  typedef struct packed {
    logic active;
    sfelp_erase_t kind;
    logic [23:0] addr;
  } sfelp_erase_req_t;

  // one captured frame from the serial side
  typedef struct packed {
    logic [5:0] bits;
    logic [39:0] shift;
  } sfelp_frame_t;

endpackage
`default_nettype wire

// [logic/sfelp_seq.sv]
// serial flash erase, lock-bit and deep power-down command sequencer
`include "sfelp_consts.svh"
`default_nettype none

// Contract
// - lock write accepted only while the write latch is set.
// - lock write runs only if deselect follows the data byte's eighth bit.
// - lock bits update at once; write latch cleared right after.
// - data bit1 is lock-down, bit0 is write-lock, rest ignored.
// - lock write, erase and power-down refused while a cycle runs.
// - page erase sets the page to ones; any address in it targets it.
// - region erases need exactly code plus three address bytes.
// - erase start sets busy until done; write latch cleared before end.
// - page erase refused on a hardware or software protected sector.
// - subsector erase refused when its region is protected.
// - sector erase refused when the sector is hardware protected.
// - bulk erase needs exactly the code byte alone.
// - bulk erase refused if any sector is protected.
// - reset pin low aborts a running cycle and enters reset mode.
// - address bits above the array size are ignored.
// - deep power-down ignores write, program and erase commands.
// - power-down entered only from standby, with no cycle running.
// - power-down is code alone; mode entered after the entry delay.
// - power-up always lands in standby, never in power-down.
// - in power-down only release is taken; standby after its delay.
// - a set lock-down bit freezes that sector's lock bits.
// - power-up clears lock bits, write latch and busy flag.
module sfelp_seq
  import sfelp_pkg::*;
#(
  parameter int ADDR_BITS = 18,
  parameter int unsigned PAGE_ERASE_CYC =
    `SFELP_PAGE_ERASE_US * `SFELP_CLK_MHZ,
  parameter int unsigned SUB_ERASE_CYC =
    `SFELP_SUB_ERASE_US * `SFELP_CLK_MHZ,
  parameter int unsigned SECT_ERASE_CYC =
    `SFELP_SECT_ERASE_US * `SFELP_CLK_MHZ,
  parameter int unsigned BULK_ERASE_CYC =
    `SFELP_BULK_ERASE_US * `SFELP_CLK_MHZ,
  localparam int SECTORS = 1 << (ADDR_BITS - `SFELP_SECT_LSB),
  localparam int SEC_W = ADDR_BITS - `SFELP_SECT_LSB
) (
  // system clock and power-up reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial link pins
  input wire logic spi_clk,
  input wire logic select_n,
  input wire logic serial_in_line,
  input wire logic reset_n,
  // hardware protection per sector, from the protect logic
  input wire logic [SECTORS-1:0] hw_protect,
  // status
  output logic busy_cycle_flag,
  output logic write_latch_flag,
  output logic deep_powerdown,
  output logic standby,
  output logic [SECTORS-1:0][7:0] sector_lock_bits,
  // erase order toward the array
  output sfelp_erase_req_t erase_req
);

  // short delays, rounded up to whole cycles
  // rounding up means the device is never ready early, at the cost of
  // at most one extra cycle of wait for the host
  localparam int unsigned PD_ENTRY_CYC =
    (`SFELP_PD_ENTRY_NS * `SFELP_CLK_MHZ + 999) / 1000;
  localparam int unsigned PD_RELEASE_CYC =
    (`SFELP_PD_RELEASE_NS * `SFELP_CLK_MHZ + 999) / 1000;
  localparam int unsigned RESET_RECOVER_CYC =
    (`SFELP_RESET_RECOVER_NS * `SFELP_CLK_MHZ + 999) / 1000;

  // refuse sizes the sector decode cannot serve
  if (ADDR_BITS < 17 || ADDR_BITS > 24) begin : g_bad_size
    $error("sfelp_seq: ADDR_BITS must lie in 17..24");
  end
  if (PAGE_ERASE_CYC == 0 || SUB_ERASE_CYC == 0 ||
      SECT_ERASE_CYC == 0 || BULK_ERASE_CYC == 0) begin : g_bad_time
    $error("sfelp_seq: erase cycle counts must be nonzero");
  end

  // link domain
  // the serial clock only runs inside frames, so the shift word and the
  // bit count hold still once select is high; the system side reads them
  // only after it has seen that deselect through its own synchroniser,
  // which makes the select pin itself the handshake between the domains
  // hazard: a host that toggles the serial clock while deselected would
  // disturb the words under the reader, which the link rules forbid

  logic first_q;
  logic [5:0] link_bits_q;
  logic [39:0] link_shift_q;

  // frame start marker, set by reset or by the previous frame's deselect
  // held set by select high, so the first rising clock of a frame
  // restarts the count without any help from the system clock
  always_ff @(posedge spi_clk or posedge select_n or posedge rst) begin
    if (rst || select_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // shift msb first and count bits, saturating so long frames fail
  // only the last forty bits are kept; longer frames are refused anyway
  // by the length decode, so nothing older is ever needed
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      link_bits_q <= 6'h00;
      link_shift_q <= 40'h00_0000_0000;
    end else if (first_q) begin
      link_bits_q <= 6'h01;
      link_shift_q <= {39'h00_0000_0000, serial_in_line};
    end else begin
      if (link_bits_q != 6'h3F) begin
        link_bits_q <= link_bits_q + 6'h01;
      end
      link_shift_q <= {link_shift_q[38:0], serial_in_line};
    end
  end

  // system domain
  // every decision is taken here, once per frame, on the synchronised
  // rising edge of select; a frame that ends while a cycle runs or while
  // powered down, release aside, is simply dropped, with no trace left behind

  logic sel_s1_q, sel_s2_q, sel_s3_q;
  logic rstn_s1_q, rstn_s2_q;
  logic [SECTORS-1:0] hwp_s1_q, hwp_s2_q;

  // two-stage synchronisers for every pin read here
  // the third select stage only feeds the edge detector; no decode logic
  // reads the first stage, which may still be settling
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      rstn_s1_q <= 1'b1;
      rstn_s2_q <= 1'b1;
      hwp_s1_q <= '0;
      hwp_s2_q <= '0;
    end else begin
      sel_s1_q <= select_n;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      rstn_s1_q <= reset_n;
      rstn_s2_q <= rstn_s1_q;
      hwp_s1_q <= hw_protect;
      hwp_s2_q <= hwp_s1_q;
    end
  end

  // end of frame; the link clock is still, so its words are steady
  logic desel;
  sfelp_frame_t frm;
  assign desel = sel_s2_q && !sel_s3_q;
  assign frm.bits = link_bits_q;
  assign frm.shift = link_shift_q;

  // frame decode by exact length
  // exact length is the only framing check: one bit short or one bit long
  // and the frame falls through every decode below
  logic is_code, is_addr, is_data;
  logic [7:0] op_code, op_addr, op_data, lock_in;
  logic [23:0] addr_raw, addr_m;
  logic [SEC_W-1:0] sec;
  assign is_code = desel && frm.bits == `SFELP_BITS_CODE;
  assign is_addr = desel && frm.bits == `SFELP_BITS_ADDR;
  assign is_data = desel && frm.bits == `SFELP_BITS_DATA;
  assign op_code = frm.shift[7:0];
  assign op_addr = frm.shift[31:24];
  assign op_data = frm.shift[39:32];
  assign lock_in = frm.shift[7:0];
  assign addr_raw = is_data ? frm.shift[31:8] : frm.shift[23:0];

  // upper address bits beyond the array are don't care
  // so an address past the top wraps onto the array instead of failing
  assign addr_m = addr_raw & 24'((1 << ADDR_BITS) - 1);
  assign sec = addr_m[ADDR_BITS-1:`SFELP_SECT_LSB];

  sfelp_state_t state_q;
  logic [31:0] timer_q;
  logic [SECTORS-1:0] sw_lock;
  logic idle, in_reset;
  assign idle = state_q == SFELP_ST_IDLE;
  assign in_reset = !rstn_s2_q;

  // command events, taken in standby with no cycle running; release only in power-down
  // a refused command leaves no mark; the host has to look at the flags
  // to learn whether its erase or lock write was taken
  logic ev_wren, ev_wrdi, ev_lock, ev_dpd, ev_rdpd;
  logic ev_page, ev_sub, ev_sect, ev_bulk, ev_erase;
  assign ev_wren = idle && is_code && op_code == `SFELP_OP_WREN;
  assign ev_wrdi = idle && is_code && op_code == `SFELP_OP_WRDI;
  assign ev_lock = idle && write_latch_flag && is_data
    && op_data == `SFELP_OP_LOCK_WR;
  assign ev_dpd = idle && is_code && op_code == `SFELP_OP_DPD;
  assign ev_rdpd = state_q == SFELP_ST_PD && is_code
    && op_code == `SFELP_OP_RDPD;

  // erase acceptance with write latch, cycle and protection checks
  assign ev_page = idle && write_latch_flag && is_addr
    && op_addr == `SFELP_OP_PAGE_ERASE
    && !hwp_s2_q[sec] && !sw_lock[sec];
  assign ev_sub = idle && write_latch_flag && is_addr
    && op_addr == `SFELP_OP_SUB_ERASE
    && !hwp_s2_q[sec] && !sw_lock[sec];
  assign ev_sect = idle && write_latch_flag && is_addr
    && op_addr == `SFELP_OP_SECT_ERASE
    && !hwp_s2_q[sec];
  assign ev_bulk = idle && write_latch_flag && is_code
    && op_code == `SFELP_OP_BULK_ERASE
    && hwp_s2_q == '0 && sw_lock == '0;
  assign ev_erase = ev_page || ev_sub || ev_sect || ev_bulk;

  // per-sector lock bytes; lock-down freezes, only power-up or reset clears
  // lock-down is sticky, so a stray write can never unlock a sector;
  // the reset pin clears it too, as the device does after a pin pulse
  for (genvar s = 0; s < SECTORS; s++) begin : g_lock
    logic [1:0] lock_q;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        lock_q <= 2'(`SFELP_LOCK_RESET);
      end else if (in_reset) begin
        lock_q <= 2'(`SFELP_LOCK_RESET);
      end else if (ev_lock && sec == SEC_W'(s)
                   && !lock_q[`SFELP_LOCK_DN_BIT]) begin
        lock_q <= lock_in[1:0];
      end
    end
    assign sw_lock[s] = lock_q[`SFELP_LOCK_WR_BIT];
    // upper six bits read as zero
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        sector_lock_bits[s] <= `SFELP_LOCK_RESET;
      end else begin
        sector_lock_bits[s] <= {6'h00, lock_q};
      end
    end
  end

  // the clear wins over the set; both come from distinct frames, so
  // they can never meet in one cycle anyway
  // write latch: a successful lock write or erase start clears it,
  // well inside the least deselect time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      write_latch_flag <= 1'b0;
    end else if (in_reset) begin
      write_latch_flag <= 1'b0;
    end else if (ev_lock || ev_erase || ev_wrdi) begin
      write_latch_flag <= 1'b0;
    end else if (ev_wren) begin
      write_latch_flag <= 1'b1;
    end
  end

  // cycle length by erase kind
  // the default only keeps the tool from seeing a latch on n
  function automatic logic [31:0] erase_len(input sfelp_erase_t k);
    logic [31:0] n;
    n = 32'(PAGE_ERASE_CYC);
    unique case (k)
      SFELP_ER_PAGE: n = 32'(PAGE_ERASE_CYC);
      SFELP_ER_SUB: n = 32'(SUB_ERASE_CYC);
      SFELP_ER_SECT: n = 32'(SECT_ERASE_CYC);
      SFELP_ER_BULK: n = 32'(BULK_ERASE_CYC);
    endcase
    return n;
  endfunction

  sfelp_erase_t kind_d;
  logic [23:0] base_d;

  // kind and aligned base address of the accepted erase
  // the array sees a region base, never the host's raw offset
  always_comb begin
    kind_d = SFELP_ER_PAGE;
    base_d = addr_m;
    if (ev_page) begin
      kind_d = SFELP_ER_PAGE;
      base_d[`SFELP_PAGE_LSB-1:0] = '0;
    end else if (ev_sub) begin
      kind_d = SFELP_ER_SUB;
      base_d[`SFELP_SUB_LSB-1:0] = '0;
    end else if (ev_sect) begin
      kind_d = SFELP_ER_SECT;
      base_d[`SFELP_SECT_LSB-1:0] = '0;
    end else if (ev_bulk) begin
      kind_d = SFELP_ER_BULK;
      base_d = 24'h00_0000;
    end
  end

  // mode sequencer with one shared down-counter; the reset pin wins
  // one counter serves every timed state, which costs a wide register
  // but keeps the machine small; durations above 2^32 cycles cannot
  // be served by this counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= SFELP_ST_IDLE;
      timer_q <= 32'h0000_0000;
    end else if (in_reset) begin
      state_q <= SFELP_ST_RESET;
      timer_q <= 32'(RESET_RECOVER_CYC);
    end else begin
      unique case (state_q)
        SFELP_ST_IDLE: begin
          if (ev_erase) begin
            state_q <= SFELP_ST_ERASE;
            timer_q <= erase_len(kind_d);
          end else if (ev_dpd) begin
            state_q <= SFELP_ST_PD_ENTRY;
            timer_q <= 32'(PD_ENTRY_CYC);
          end
        end
        SFELP_ST_ERASE, SFELP_ST_PD_ENTRY, SFELP_ST_PD_EXIT,
        SFELP_ST_RESET: begin
          if (timer_q > 32'h0000_0001) begin
            timer_q <= timer_q - 32'h0000_0001;
          end else if (state_q == SFELP_ST_PD_ENTRY) begin
            state_q <= SFELP_ST_PD;
            timer_q <= 32'h0000_0000;
          end else begin
            state_q <= SFELP_ST_IDLE;
            timer_q <= 32'h0000_0000;
          end
        end
        SFELP_ST_PD: begin
          // every frame but release is dropped here
          if (ev_rdpd) begin
            state_q <= SFELP_ST_PD_EXIT;
            timer_q <= 32'(PD_RELEASE_CYC);
          end
        end
      endcase
    end
  end

  // erase order held for the whole cycle, withdrawn on reset abort
  // it drops on the same edge as busy, so the two always read alike
  // and the array never works past the flag the host polls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      erase_req <= '0;
    end else if (in_reset) begin
      erase_req <= '0;
    end else if (ev_erase) begin
      erase_req <= '{active: 1'b1, kind: kind_d, addr: base_d};
    end else if (state_q == SFELP_ST_ERASE && timer_q <= 32'h0000_0001) begin
      erase_req.active <= 1'b0;
    end
  end

  // status outputs from flops
  // standby drops in the very cycle an erase is taken, so it never
  // overlaps the busy flag that rises on that same edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_cycle_flag <= 1'b0;
      deep_powerdown <= 1'b0;
      standby <= 1'b1;
    end else begin
      busy_cycle_flag <= !in_reset && (ev_erase ||
        (state_q == SFELP_ST_ERASE && timer_q > 32'h0000_0001));
      deep_powerdown <= !in_reset && state_q == SFELP_ST_PD;
      // standby only when deselected with no cycle running
      standby <= !in_reset && sel_s2_q && idle
        && !ev_erase;
    end
  end

endmodule
`default_nettype wire

// [sim/sfelp_host.sv]
// host-side serial controller model for the link pins
`default_nettype none
module sfelp_host (
  // link pins
  output logic spi_clk,
  output logic select_n,
  output logic serial_in_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_clk = 1'b0;
    select_n = 1'b1;
    serial_in_line = 1'b0;
  end
  // one frame at 32 ns per bit; clock stands still outside frames
  task automatic frame(input int n, input logic [39:0] v);
    select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line = v[i];
      #16 spi_clk = 1'b1;
      #16 spi_clk = 1'b0;
    end
    #16 select_n = 1'b1;
    serial_in_line = ~serial_in_line; // no stale bit once released
    #200; // deselect gap well above five system cycles
  endtask
endmodule
`default_nettype wire

// [sim/sfelp_seq_checker.sv]
// port assertions for the erase, lock and power-down sequencer
`default_nettype none
module sfelp_checker
  import sfelp_pkg::*;
#(
  parameter int ADDR_BITS = 18,
  localparam int SECTORS = 1 << (ADDR_BITS - 16)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pins
  input wire logic spi_clk,
  input wire logic select_n,
  input wire logic serial_in_line,
  input wire logic reset_n,
  input wire logic [SECTORS-1:0] hw_protect,
  // status
  input wire logic busy_cycle_flag,
  input wire logic write_latch_flag,
  input wire logic deep_powerdown,
  input wire logic standby,
  input wire logic [SECTORS-1:0][7:0] sector_lock_bits,
  input wire sfelp_erase_req_t erase_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // busy and the erase order are one fact seen twice
  property p_busy_req; busy_cycle_flag == erase_req.active; endproperty
  a_busy_req: assert property (p_busy_req)
    else $error("busy flag and erase order disagree");
  property p_latch_start; $rose(busy_cycle_flag) |-> !write_latch_flag;
  endproperty
  a_latch_start: assert property (p_latch_start)
    else $error("write latch still set at erase start");
  property p_start_desel;
    $rose(busy_cycle_flag) |-> select_n && $past(select_n, 2);
  endproperty
  a_start_desel: assert property (p_start_desel)
    else $error("erase started without a deselect");
  property p_pd_idle; deep_powerdown |-> !busy_cycle_flag; endproperty
  a_pd_idle: assert property (p_pd_idle)
    else $error("power-down while a cycle runs");
  property p_standby;
    standby |-> !busy_cycle_flag && !deep_powerdown;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby shown with a cycle or power-down");
  property p_lock_rsv;
    (sector_lock_bits & {SECTORS{8'hFC}}) == '0;
  endproperty
  a_lock_rsv: assert property (p_lock_rsv)
    else $error("reserved lock bits set");
  // four quiet pin cycles rule out a pending pin clear
  property p_lock_down;
    (sector_lock_bits[1][1] && reset_n) [*4] |=>
      $stable(sector_lock_bits[1]);
  endproperty
  a_lock_down: assert property (p_lock_down)
    else $error("locked-down bits changed");
  property p_pin_abort;
    !reset_n [*4] |=> !busy_cycle_flag && !write_latch_flag && !standby
      && sector_lock_bits == '0;
  endproperty
  a_pin_abort: assert property (p_pin_abort)
    else $error("reset pin did not abort and clear");
  property p_req_hold;
    erase_req.active && $past(erase_req.active) |->
      $stable(erase_req.addr) && $stable(erase_req.kind);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("erase target moved mid-cycle");
  property p_pd_rise;
    $rose(deep_powerdown) |-> select_n && !busy_cycle_flag;
  endproperty
  a_pd_rise: assert property (p_pd_rise)
    else $error("power-down entered while selected or busy");
endmodule
bind sfelp_seq sfelp_checker #(.ADDR_BITS(ADDR_BITS)) u_sfelp_checker (
  .clk_sys(clk_sys), .rst(rst), .spi_clk(spi_clk), .select_n(select_n),
  .serial_in_line(serial_in_line), .reset_n(reset_n),
  .hw_protect(hw_protect), .busy_cycle_flag(busy_cycle_flag),
  .write_latch_flag(write_latch_flag), .deep_powerdown(deep_powerdown),
  .standby(standby), .sector_lock_bits(sector_lock_bits),
  .erase_req(erase_req)
);
`default_nettype wire

// [sim/tb_serial_flash_erase_lock_powerdown.sv]
// self-checking bench for the erase, lock and power-down sequencer
`include "sfelp_consts.svh"
`default_nettype none
module tb_serial_flash_erase_lock_powerdown import sfelp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // short erase counts keep the run brief
  localparam int PG = 40, SB = 400, SC = 80, BK = 100;
  logic clk_sys = 1'b0, rst = 1'b1, reset_n = 1'b1;
  logic [3:0] hw_protect = 4'h0;
  wire logic spi_clk, select_n, serial_in_line;
  logic busy_cycle_flag, write_latch_flag, deep_powerdown, standby;
  logic [3:0][7:0] sector_lock_bits;
  sfelp_erase_req_t erase_req;
  int error_cnt = 0, cmp_count = 0;
  typedef struct packed {
    logic wren; logic [5:0] n; logic [39:0] v; logic go;
    sfelp_erase_t kind; logic [23:0] addr;
  } sfelp_row_t;
  // erase rows: latch, frame, expected start and target
  sfelp_row_t rows [8] = '{
    '{1'b1, `SFELP_BITS_ADDR, {`SFELP_OP_PAGE_ERASE, 24'h01_2345}, 1'b1,
      SFELP_ER_PAGE, 24'h01_2300},
    '{1'b1, `SFELP_BITS_ADDR, {`SFELP_OP_SUB_ERASE, 24'h02_ABCD}, 1'b1,
      SFELP_ER_SUB, 24'h02_A000},
    '{1'b1, `SFELP_BITS_ADDR, {`SFELP_OP_SECT_ERASE, 24'h03_FFFF}, 1'b1,
      SFELP_ER_SECT, 24'h03_0000},
    '{1'b1, `SFELP_BITS_CODE, `SFELP_OP_BULK_ERASE, 1'b1,
      SFELP_ER_BULK, 24'h00_0000},
    '{1'b1, `SFELP_BITS_ADDR, {`SFELP_OP_PAGE_ERASE, 24'hFC_1234}, 1'b1,
      SFELP_ER_PAGE, 24'h00_1200},
    '{1'b1, `SFELP_BITS_DATA, {`SFELP_OP_PAGE_ERASE, 32'h0010_0000}, 1'b0,
      SFELP_ER_PAGE, 24'h00_0000},
    '{1'b1, 6'h10, {`SFELP_OP_BULK_ERASE, 8'h00}, 1'b0,
      SFELP_ER_BULK, 24'h00_0000},
    '{1'b0, `SFELP_BITS_ADDR, {`SFELP_OP_SECT_ERASE, 24'h00_0000}, 1'b0,
      SFELP_ER_SECT, 24'h00_0000}
  };
  always #10 clk_sys = ~clk_sys;
  sfelp_seq #(.PAGE_ERASE_CYC(PG), .SUB_ERASE_CYC(SB), .SECT_ERASE_CYC(SC),
    .BULK_ERASE_CYC(BK)) u_sfelp_seq (
    .clk_sys(clk_sys), .rst(rst), .spi_clk(spi_clk), .select_n(select_n),
    .serial_in_line(serial_in_line), .reset_n(reset_n),
    .hw_protect(hw_protect), .busy_cycle_flag(busy_cycle_flag),
    .write_latch_flag(write_latch_flag), .deep_powerdown(deep_powerdown),
    .standby(standby), .sector_lock_bits(sector_lock_bits),
    .erase_req(erase_req));
  sfelp_host u_sfelp_host (.spi_clk(spi_clk), .select_n(select_n),
    .serial_in_line(serial_in_line));
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // settle one ns past the edge so design updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic tx(input int n, input logic [39:0] v);
    u_sfelp_host.frame(n, v);
    cyc(2);
  endtask
  function automatic int len(input sfelp_erase_t k);
    return k == SFELP_ER_PAGE ? PG : k == SFELP_ER_SUB ? SB :
      k == SFELP_ER_SECT ? SC : BK;
  endfunction
  // busy began about ten cycles before this is entered
  task automatic wait_idle(input int n);
    int c;
    c = 0;
    while (busy_cycle_flag === 1'b1 && c < n + 50) begin
      cyc(1);
      c++;
    end
    chk(c > n - 20 && c < n, 1'b1);
  endtask
  initial begin
    #1_000_000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    cyc(12);
    @(posedge clk_sys) rst <= 1'b0;
    cyc(3);
    chk({busy_cycle_flag, write_latch_flag, deep_powerdown, standby,
      sector_lock_bits}, {4'h1, 32'h0});
    foreach (rows[i]) begin
      tx(8, rows[i].wren ? `SFELP_OP_WREN : `SFELP_OP_WRDI);
      tx(rows[i].n, rows[i].v);
      chk(erase_req.active, rows[i].go);
      chk(write_latch_flag, rows[i].wren && !rows[i].go);
      if (rows[i].go) begin
        chk({erase_req.kind, erase_req.addr},
          {rows[i].kind, rows[i].addr});
        wait_idle(len(rows[i].kind));
      end
    end
    // lock sector 1, then erases aimed at it must be refused
    tx(8, `SFELP_OP_WREN);
    tx(`SFELP_BITS_DATA, {`SFELP_OP_LOCK_WR, 32'h0100_0001});
    chk(sector_lock_bits[1], 8'h01);
    chk(write_latch_flag, 1'b0);
    tx(8, `SFELP_OP_WREN);
    tx(`SFELP_BITS_ADDR, {`SFELP_OP_PAGE_ERASE, 24'h01_0400});
    chk(busy_cycle_flag, 1'b0);
    tx(`SFELP_BITS_CODE, `SFELP_OP_BULK_ERASE);
    chk(busy_cycle_flag, 1'b0);
    tx(`SFELP_BITS_DATA, {`SFELP_OP_LOCK_WR, 32'h0180_00FE});
    chk(sector_lock_bits[1], 8'h02);
    tx(8, `SFELP_OP_WREN);
    tx(`SFELP_BITS_DATA, {`SFELP_OP_LOCK_WR, 32'h0100_0000});
    chk(sector_lock_bits[1], 8'h02);
    // hardware protection of sector 3
    @(posedge clk_sys) hw_protect <= 4'h8;
    tx(8, `SFELP_OP_WREN);
    tx(`SFELP_BITS_ADDR, {`SFELP_OP_SECT_ERASE, 24'h03_0000});
    chk(busy_cycle_flag, 1'b0);
    tx(`SFELP_BITS_ADDR, {`SFELP_OP_SUB_ERASE, 24'h03_1000});
    chk(busy_cycle_flag, 1'b0);
    @(posedge clk_sys) hw_protect <= 4'h0;
    // power-down refused mid-erase, then the pin aborts the erase
    tx(`SFELP_BITS_ADDR, {`SFELP_OP_SUB_ERASE, 24'h00_1000});
    tx(`SFELP_BITS_CODE, `SFELP_OP_DPD);
    cyc(160);
    chk({busy_cycle_flag, deep_powerdown}, 2'b10);
    @(posedge clk_sys) reset_n <= 1'b0;
    cyc(6);
    chk({busy_cycle_flag, write_latch_flag, sector_lock_bits}, 0);
    @(posedge clk_sys) reset_n <= 1'b1;
    cyc(1600);
    // power-down entry, lockout and release
    tx(6'h10, {`SFELP_OP_DPD, 8'h00});
    cyc(160);
    chk(deep_powerdown, 1'b0);
    tx(`SFELP_BITS_CODE, `SFELP_OP_DPD);
    chk(deep_powerdown, 1'b0);
    cyc(150);
    chk({deep_powerdown, standby}, 2'b10);
    tx(8, `SFELP_OP_WREN);
    tx(`SFELP_BITS_CODE, `SFELP_OP_BULK_ERASE);
    chk(busy_cycle_flag, 1'b0);
    tx(`SFELP_BITS_CODE, `SFELP_OP_RDPD);
    chk({deep_powerdown, standby}, 2'b00);
    cyc(1500);
    chk({deep_powerdown, standby}, 2'b01);
    // power-up from within power-down lands in standby
    tx(`SFELP_BITS_CODE, `SFELP_OP_DPD);
    cyc(160);
    @(posedge clk_sys) rst <= 1'b1;
    cyc(2);
    chk({deep_powerdown, standby}, 2'b01);
    @(posedge clk_sys) rst <= 1'b0;
    cyc(3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
